// File: verilog/dsa_pkg.sv
// Shared constants, enumerations and carriers of the data-space access unit.
`default_nettype none
package dsa_pkg;
  localparam int DSA_AW      = 16;
  localparam int DSA_DW      = 16;
  localparam int DSA_PAGE_W  = 8;
  localparam int DSA_NEAR_W  = 13;
  localparam int DSA_IDX_W   = 14;
  localparam int DSA_PROG_AW = DSA_PAGE_W + DSA_IDX_W;
  localparam int DSA_WIN_BIT = 15;
  localparam int DSA_LANES   = 2;
  localparam int DSA_WORDS   = 15360;
  localparam logic [15:0] DSA_CTL_LAST  = 16'h07FF;
  localparam logic [15:0] DSA_NEAR_LAST = 16'h1FFF;
  localparam logic [15:0] DSA_DATA_LAST = 16'h77FF;
  localparam logic [15:0] DSA_DMA_BASE  = 16'h7000;
  localparam logic [15:0] DSA_DMA_LAST  = 16'h77FF;
  localparam logic [15:0] DSA_XY_BOUND  = 16'h4800;
  localparam logic [15:0] DSA_STEP_BYTE = 16'h0001;
  localparam logic [15:0] DSA_STEP_WORD = 16'h0002;
  localparam logic [15:0] DSA_ZERO_W    = 16'h0000;
  localparam logic [7:0]  DSA_ZERO_B    = 8'h00;
  localparam logic [1:0]  DSA_LANE_NONE = 2'h0;
  localparam logic [1:0]  DSA_LANE_LO   = 2'h1;
  localparam logic [1:0]  DSA_LANE_HI   = 2'h2;
  localparam logic [1:0]  DSA_LANE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    DSA_AM_DIRECT,
    DSA_AM_POSTINC,
    DSA_AM_MODULO,
    DSA_AM_BITREV
  } dsa_amode_t;

  typedef enum logic [1:0] {
    DSA_RG_CTL,
    DSA_RG_RAM,
    DSA_RG_WINDOW,
    DSA_RG_EMPTY
  } dsa_region_t;

  typedef struct packed {
    logic        valid;
    logic        byte_op;
    dsa_amode_t  mode;
    logic [15:0] ptr;
  } dsa_agu_req_t;

  typedef struct packed {
    logic [15:0] start;
    logic [15:0] last;
    logic [15:0] brev_step;
  } dsa_circ_cfg_t;
endpackage : dsa_pkg
`default_nettype wire

// File: verilog/dsa_addr_gen.sv
// Address generator: effective address and pointer update for one port.
`timescale 1ns/10ps
`default_nettype none
module dsa_addr_gen #(
  parameter bit BITREV_EN = 1'b1
) (
  input  wire dsa_pkg::dsa_agu_req_t  req_in,
  input  wire dsa_pkg::dsa_circ_cfg_t cfg_in,
  output logic [15:0]                 ea_out,
  output logic [15:0]                 ptr_next_out
);
  import dsa_pkg::*;

  function automatic logic [14:0] rev15(input logic [14:0] v);
    for (int i = 0; i < 15; i++)
      rev15[i] = v[14 - i];
  endfunction : rev15

  logic [15:0] step;
  logic [15:0] inc;
  logic [14:0] brev_sum;

  always_comb
  begin
    step     = req_in.byte_op ? DSA_STEP_BYTE : DSA_STEP_WORD;
    inc      = 16'(req_in.ptr + step);
    // Carry runs from high to low bit, so the buffer base must be aligned.
    brev_sum = rev15(15'(rev15(req_in.ptr[15:1])
                         + rev15(cfg_in.brev_step[15:1])));
    ea_out   = req_in.ptr;
    unique case (req_in.mode)
      DSA_AM_DIRECT:  ptr_next_out = req_in.ptr;
      DSA_AM_POSTINC: ptr_next_out = inc;
      DSA_AM_MODULO:
        ptr_next_out = (inc > cfg_in.last) ? cfg_in.start : inc;
      DSA_AM_BITREV:
        ptr_next_out = BITREV_EN ? {brev_sum, req_in.ptr[0]} : inc;
    endcase
  end
endmodule : dsa_addr_gen
`default_nettype wire

// File: verilog/dsa_lane_mem.sv
// Data RAM of two byte lanes with shared word decode and two read ports.
`timescale 1ns/10ps
`default_nettype none
module dsa_lane_mem #(
  parameter int WORDS = dsa_pkg::DSA_WORDS
) (
  input  wire logic                          core_clk_in,
  input  wire logic [dsa_pkg::DSA_IDX_W-1:0] wr_index_in,
  input  wire logic [1:0]                    wr_strb_in,
  input  wire logic [15:0]                   wr_data_in,
  input  wire logic [dsa_pkg::DSA_IDX_W-1:0] xr_index_in,
  output logic      [15:0]                   xr_data_out,
  input  wire logic [dsa_pkg::DSA_IDX_W-1:0] yr_index_in,
  output logic      [15:0]                   yr_data_out
);
  import dsa_pkg::*;

  genvar g;
  generate
    for (g = 0; g < DSA_LANES; g++)
    begin : g_lane
      logic [7:0] lane_mem [WORDS];
      always_ff @(posedge core_clk_in)
      begin
        if (wr_strb_in[g])
          lane_mem[wr_index_in] <= wr_data_in[8*g +: 8];
      end
      assign xr_data_out[8*g +: 8] = lane_mem[xr_index_in];
      assign yr_data_out[8*g +: 8] = lane_mem[yr_index_in];
    end
  endgenerate
endmodule : dsa_lane_mem
`default_nettype wire

// File: verilog/dsa_access_unit.sv
// Data-space access unit: decode, byte lanes, window, alignment traps.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Every effective address is sixteen bits and selects one byte.
// - Top address bit clear selects data memory, set selects program window.
// - Up to 30 KB data memory; reads outside it return zero.
// - Words hold two byte lanes, low byte even, high byte odd.
// - Post-increment adds one for bytes and two for words.
// - Byte reads fetch the word and steer the chosen byte to low lane.
// - Byte writes strobe only the matching lane over a shared word decode.
// - Odd X-read or write word access is never split and raises an address error trap unless a fault is pending and not acknowledged that cycle.
// - Misaligned read completes, misaligned write is dropped; trap follows unless a fault is pending and not being acknowledged.
// - Byte loads replace the register low byte and keep its high byte.
// - Addresses up to the first 2 KB reach the control registers.
// - Unused control-region addresses read as zero.
// - Upper 32 KB may map to program memory by an 8-bit page.
// - General accesses use X only; dual-operand ops also use Y.
// - X and Y generators both support circular buffer addressing.
// - The X generator also supports bit-reversed sequencing.
// - Separate read and write generators allow both in one cycle.
// - A 2 KB DMA region is also plain general-purpose RAM.
// - First 8 KB reachable by a 13-bit near field, all by 16 bits.
module dsa_access_unit #(
  parameter logic [15:0] DATA_LAST = dsa_pkg::DSA_DATA_LAST,
  parameter logic [15:0] XY_BOUND  = dsa_pkg::DSA_XY_BOUND,
  parameter logic [15:0] DMA_BASE  = dsa_pkg::DSA_DMA_BASE,
  parameter logic [15:0] DMA_LAST  = dsa_pkg::DSA_DMA_LAST,
  parameter int          WORDS     = dsa_pkg::DSA_WORDS
) (
  input  wire logic                            core_clk_in,
  input  wire logic                            rst_n_in,
  input  wire dsa_pkg::dsa_agu_req_t           x_req_in,
  input  wire dsa_pkg::dsa_circ_cfg_t          x_cfg_in,
  input  wire logic                            near_direct_in,
  input  wire dsa_pkg::dsa_agu_req_t           y_req_in,
  input  wire dsa_pkg::dsa_circ_cfg_t          y_cfg_in,
  input  wire logic                            dual_op_in,
  input  wire dsa_pkg::dsa_agu_req_t           w_req_in,
  input  wire dsa_pkg::dsa_circ_cfg_t          w_cfg_in,
  input  wire logic [15:0]                     wdata_in,
  input  wire logic [15:0]                     wreg_old_in,
  input  wire logic                            window_enable_in,
  input  wire logic [dsa_pkg::DSA_PAGE_W-1:0]  program_window_page_in,
  input  wire logic [15:0]                     prog_data_in,
  input  wire logic [15:0]                     ctl_rdata_in,
  input  wire logic                            ctl_rhit_in,
  input  wire logic                            trap_ack_in,
  output logic      [15:0]                     x_ptr_next_out,
  output logic      [15:0]                     y_ptr_next_out,
  output logic      [15:0]                     w_ptr_next_out,
  output logic      [15:0]                     x_rdata_out,
  output logic                                 x_rvalid_out,
  output logic                                 x_dma_region_out,
  output logic      [15:0]                     y_rdata_out,
  output logic                                 y_rvalid_out,
  output logic      [15:0]                     wreg_out,
  output logic                                 wr_done_out,
  output logic                                 wr_dropped_out,
  output logic                                 prog_rd_out,
  output logic      [dsa_pkg::DSA_PROG_AW-1:0] prog_addr_out,
  output logic                                 ctl_rd_out,
  output logic      [15:0]                     ctl_raddr_out,
  output logic                                 ctl_wr_out,
  output logic      [15:0]                     ctl_waddr_out,
  output logic      [1:0]                      ctl_wstrb_out,
  output logic      [15:0]                     ctl_wdata_out,
  output logic                                 addr_err_trap_out,
  output logic                                 fault_pending_out,
  output logic      [15:0]                     fault_addr_out
);
  import dsa_pkg::*;

  typedef struct packed {
    logic [15:0] x_rdata;
    logic        x_rvalid;
    logic        x_dma;
    logic [15:0] y_rdata;
    logic        y_rvalid;
    logic [15:0] wreg;
    logic        wr_done;
    logic        wr_dropped;
    logic        trap;
    logic        pend;
    logic [15:0] fault_addr;
  } dsa_state_t;

  localparam dsa_state_t DSA_STATE_RST = '0;

  dsa_state_t state_reg;
  dsa_state_t state_next;

  // Region decode shared by the read and write paths.
  function automatic dsa_region_t region_of(input logic [15:0] ea,
                                            input logic        win_en);
    if (ea[DSA_WIN_BIT])
    begin
      region_of = win_en ? DSA_RG_WINDOW : DSA_RG_EMPTY;
    end
    else if (ea <= DSA_CTL_LAST)
    begin
      region_of = DSA_RG_CTL;
    end
    else if (ea <= DATA_LAST)
    begin
      region_of = DSA_RG_RAM;
    end
    else
    begin
      region_of = DSA_RG_EMPTY;
    end
  endfunction : region_of

  // The selected byte always lands on the low lane.
  function automatic logic [7:0] pick_byte(input logic [15:0] word,
                                           input logic        odd);
    pick_byte = odd ? word[15:8] : word[7:0];
  endfunction : pick_byte

  function automatic logic [1:0] lanes_of(input logic byte_op,
                                          input logic odd);
    if (!byte_op)
    begin
      lanes_of = DSA_LANE_BOTH;
    end
    else
    begin
      lanes_of = odd ? DSA_LANE_HI : DSA_LANE_LO;
    end
  endfunction : lanes_of

  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic [15:0] w_ea;
  logic [15:0] x_addr;
  logic [15:0] x_mem;
  logic [15:0] y_mem;
  logic [1:0]  mem_strb;
  logic [15:0] mem_wdata;

  // Read and write paths each own a generator, so both run per cycle.
  dsa_addr_gen #(
    .BITREV_EN (1'b1)
  ) u_x_gen (
    .req_in       (x_req_in),
    .cfg_in       (x_cfg_in),
    .ea_out       (x_ea),
    .ptr_next_out (x_ptr_next_out)
  );

  // Bit reversal is an X-side feature; here that mode falls back.
  dsa_addr_gen #(
    .BITREV_EN (1'b0)
  ) u_y_gen (
    .req_in       (y_req_in),
    .cfg_in       (y_cfg_in),
    .ea_out       (y_ea),
    .ptr_next_out (y_ptr_next_out)
  );

  dsa_addr_gen #(
    .BITREV_EN (1'b1)
  ) u_w_gen (
    .req_in       (w_req_in),
    .cfg_in       (w_cfg_in),
    .ea_out       (w_ea),
    .ptr_next_out (w_ptr_next_out)
  );

  dsa_lane_mem #(
    .WORDS (WORDS)
  ) u_mem (
    .core_clk_in (core_clk_in),
    .wr_index_in (w_ea[DSA_IDX_W:1]),
    .wr_strb_in  (mem_strb),
    .wr_data_in  (mem_wdata),
    .xr_index_in (x_addr[DSA_IDX_W:1]),
    .xr_data_out (x_mem),
    .yr_index_in (y_ea[DSA_IDX_W:1]),
    .yr_data_out (y_mem)
  );

  // Near direct forms carry only 13 address bits, zero-extended.
  always_comb
  begin
    if (near_direct_in && x_req_in.mode == DSA_AM_DIRECT)
    begin
      x_addr = {{(DSA_AW - DSA_NEAR_W){1'b0}},
                x_ea[DSA_NEAR_W-1:0]};
    end
    else
    begin
      x_addr = x_ea;
    end
  end

  dsa_region_t x_rg;
  dsa_region_t w_rg;
  logic [15:0] x_word;
  logic [15:0] y_word;
  logic [7:0]  x_byte;
  logic        x_mis;
  logic        w_mis;
  logic        w_go;
  logic        y_go;
  logic        y_ok;

  logic        fault;
  logic [15:0] fault_ea;

  always_comb
  begin
    x_rg = region_of(x_addr, window_enable_in);
    // The window is read-only, so writes there decode as empty.
    w_rg = region_of(w_ea, 1'b0);

    // Odd word accesses are never split into two byte cycles.
    x_mis = x_req_in.valid && !x_req_in.byte_op && x_addr[0];
    w_mis = w_req_in.valid && !w_req_in.byte_op && w_ea[0];
    w_go  = w_req_in.valid && !w_mis;

    // A misaligned read still fetches the containing aligned word.
    unique case (x_rg)
      DSA_RG_RAM:    x_word = x_mem;
      DSA_RG_CTL:    x_word = ctl_rhit_in ? ctl_rdata_in : DSA_ZERO_W;
      DSA_RG_WINDOW: x_word = prog_data_in;
      DSA_RG_EMPTY:  x_word = DSA_ZERO_W;
    endcase

    x_byte = pick_byte(x_word, x_addr[0]);

    // Y serves only dual-operand ops, and only its own RAM region.
    y_go   = y_req_in.valid && dual_op_in;
    y_ok   = !y_ea[DSA_WIN_BIT] && y_ea >= XY_BOUND
             && y_ea <= DATA_LAST;
    y_word = y_ok ? y_mem : DSA_ZERO_W;

    mem_strb  = (w_go && w_rg == DSA_RG_RAM)
                ? lanes_of(w_req_in.byte_op, w_ea[0]) : DSA_LANE_NONE;
    // Byte data rides both lanes; the strobe picks the side written.
    mem_wdata = w_req_in.byte_op ? {2{wdata_in[7:0]}} : wdata_in;

    // An X fault wins when both ports misalign in one cycle.
    fault    = x_mis || w_mis;
    fault_ea = x_mis ? x_addr : w_ea;
  end

  // Program word address: the page picks a 16K-word block.
  always_comb
  begin
    prog_rd_out   = x_req_in.valid && x_rg == DSA_RG_WINDOW;
    prog_addr_out = {program_window_page_in,
                     x_addr[DSA_IDX_W:1]};

    ctl_rd_out    = x_req_in.valid && x_rg == DSA_RG_CTL;
    ctl_raddr_out = x_addr;
    ctl_waddr_out = w_ea;
    ctl_wdata_out = mem_wdata;
    // Idle lanes stay low, so a stray far-side write moves nothing.
    ctl_wr_out    = 1'b0;
    ctl_wstrb_out = DSA_LANE_NONE;
    if (w_go && w_rg == DSA_RG_CTL)
    begin
      ctl_wr_out    = 1'b1;
      ctl_wstrb_out = lanes_of(w_req_in.byte_op, w_ea[0]);
    end
  end

  always_comb
  begin
    state_next = state_reg;

    state_next.x_rvalid = x_req_in.valid;
    if (x_req_in.valid)
    begin
      if (x_req_in.byte_op)
      begin
        state_next.x_rdata = {DSA_ZERO_B, x_byte};
        state_next.wreg    = {wreg_old_in[15:8], x_byte};
      end
      else
      begin
        state_next.x_rdata = x_word;
        state_next.wreg    = x_word;
      end

      // The DMA block is ordinary RAM; this flag only reports the hit.
      state_next.x_dma = x_rg == DSA_RG_RAM && x_addr >= DMA_BASE
                         && x_addr <= DMA_LAST;
    end

    // Y bytes are zero-extended just as X bytes are.
    state_next.y_rvalid = y_go;
    if (y_go)
    begin
      if (y_req_in.byte_op)
        state_next.y_rdata = {DSA_ZERO_B, pick_byte(y_word, y_ea[0])};
      else
        state_next.y_rdata = y_word;
    end

    state_next.wr_done    = w_go;
    state_next.wr_dropped = w_mis;

    // A new fault in the acknowledge cycle is kept, not lost.
    state_next.trap = 1'b0;
    if (trap_ack_in)
    begin
      state_next.pend = 1'b0;
    end
    if (fault && (!state_reg.pend || trap_ack_in))
    begin
      state_next.trap       = 1'b1;
      state_next.pend       = 1'b1;
      state_next.fault_addr = fault_ea;
    end
  end

  // Only this state is reset; the RAM keeps whatever it held.
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      state_reg <= DSA_STATE_RST;
    else
      state_reg <= state_next;
  end

  // Data outputs come straight from flip-flops, never from the decode.
  assign x_rdata_out       = state_reg.x_rdata;
  assign x_rvalid_out      = state_reg.x_rvalid;
  assign x_dma_region_out  = state_reg.x_dma;
  assign y_rdata_out       = state_reg.y_rdata;
  assign y_rvalid_out      = state_reg.y_rvalid;
  assign wreg_out          = state_reg.wreg;
  assign wr_done_out       = state_reg.wr_done;
  assign wr_dropped_out    = state_reg.wr_dropped;
  assign addr_err_trap_out = state_reg.trap;
  assign fault_pending_out = state_reg.pend;
  assign fault_addr_out    = state_reg.fault_addr;
endmodule : dsa_access_unit
`default_nettype wire

// File: bench/dsa_access_checker.sv
// Concurrent checks on the ports of the data-space access unit.
`timescale 1ns/10ps
`default_nettype none
module dsa_access_checker
  import dsa_pkg::*;
#(
  parameter logic [15:0] DATA_LAST = DSA_DATA_LAST
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire dsa_agu_req_t x_req_in,
  input  wire dsa_agu_req_t w_req_in,
  input  wire logic         near_direct_in,
  input  wire logic         window_enable_in,
  input  wire logic [7:0]   program_window_page_in,
  input  wire logic         trap_ack_in,
  input  wire logic [15:0]  wreg_old_in,
  input  wire logic [15:0]  x_ptr_next_out,
  input  wire logic [15:0]  x_rdata_out,
  input  wire logic [15:0]  wreg_out,
  input  wire logic         wr_done_out,
  input  wire logic         wr_dropped_out,
  input  wire logic         prog_rd_out,
  input  wire logic [21:0]  prog_addr_out,
  input  wire logic         ctl_wr_out,
  input  wire logic [1:0]   ctl_wstrb_out,
  input  wire logic         addr_err_trap_out,
  input  wire logic         fault_pending_out,
  input  wire logic [15:0]  fault_addr_out
);
  logic        x_dir;
  logic        w_dir;
  logic [15:0] x_ptr;
  // The address equals the pointer in every mode; x_dir leaves out near direct forms.
  assign x_ptr = x_req_in.ptr;
  assign x_dir = x_req_in.valid && x_req_in.mode == DSA_AM_DIRECT
                 && !near_direct_in;
  assign w_dir = w_req_in.valid && w_req_in.mode == DSA_AM_DIRECT;
  default clocking dflt @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_step;
    x_req_in.valid && x_req_in.mode == DSA_AM_POSTINC |->
      x_ptr_next_out == x_ptr + (x_req_in.byte_op ? 16'h0001 : 16'h0002);
  endproperty
  a_step: assert property (p_step)
    else $error("post-increment step wrong");
  property p_zero;
    x_dir && x_ptr > DATA_LAST && !x_ptr[15] |=> x_rdata_out == 16'h0000;
  endproperty
  a_zero: assert property (p_zero)
    else $error("read beyond data memory not zero");
  property p_byte_ld;
    x_req_in.valid && x_req_in.byte_op |=> wreg_out[7:0] == x_rdata_out[7:0]
      && ((wreg_out ^ $past(wreg_old_in)) >> 8) == 16'h0000;
  endproperty
  a_byte_ld: assert property (p_byte_ld)
    else $error("byte load disturbed register high byte");
  property p_trap;
    x_dir && !x_req_in.byte_op && x_ptr[0] && !fault_pending_out |=>
      addr_err_trap_out && fault_addr_out == $past(x_ptr);
  endproperty
  a_trap: assert property (p_trap)
    else $error("odd word read did not trap");
  property p_held;
    fault_pending_out && !trap_ack_in |=>
      fault_pending_out && $stable(fault_addr_out) && !addr_err_trap_out;
  endproperty
  a_held: assert property (p_held)
    else $error("fault not held until taken");
  property p_wr_drop;
    w_dir && !w_req_in.byte_op && w_req_in.ptr[0] |->
      !ctl_wr_out ##1 wr_dropped_out && !wr_done_out;
  endproperty
  a_wr_drop: assert property (p_wr_drop)
    else $error("odd word write not suppressed");
  property p_strobe;
    ctl_wr_out && w_dir && w_req_in.byte_op |->
      ctl_wstrb_out == (w_req_in.ptr[0] ? DSA_LANE_HI : DSA_LANE_LO);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("byte write strobe on wrong lane");
  property p_window;
    x_dir && x_ptr[15] && window_enable_in |->
      prog_rd_out && prog_addr_out == {program_window_page_in, x_ptr[14:1]};
  endproperty
  a_window: assert property (p_window)
    else $error("program window address wrong");
endmodule : dsa_access_checker
bind dsa_access_unit dsa_access_checker #(.DATA_LAST(DATA_LAST))
  dsa_access_checker_inst (.*);
`default_nettype wire

// File: bench/dsa_far_model.sv
// Control-register bank and program memory beyond the access unit.
`timescale 1ns/10ps
`default_nettype none
module dsa_far_model (
  input  wire logic        core_clk_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] raddr_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] waddr_in,
  input  wire logic [1:0]  wstrb_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        prd_in,
  input  wire logic [21:0] paddr_in,
  output logic      [15:0] rdata_out,
  output logic             rhit_out,
  output logic      [15:0] pdata_out
);
  // Only eight words exist; other addresses answer junk with no hit.
  logic [15:0] bank [8];
  logic [15:0] noise_reg = 16'h0000;
  logic        hit;
  always @(posedge core_clk_in)
  begin
    noise_reg <= noise_reg + 16'h1357;
    if (wr_in && waddr_in[15:4] == 12'h002)
    begin
      if (wstrb_in[0])
        bank[waddr_in[3:1]][7:0] <= wdata_in[7:0];
      if (wstrb_in[1])
        bank[waddr_in[3:1]][15:8] <= wdata_in[15:8];
    end
  end
  // Idle lines carry changing junk so a stale value never passes for data.
  assign hit = raddr_in[15:4] == 12'h002;
  assign rhit_out = rd_in ? hit : noise_reg[0];
  assign rdata_out = !rd_in ? noise_reg
                     : hit ? bank[raddr_in[3:1]] : ~raddr_in;
  assign pdata_out = prd_in ? paddr_in[15:0] ^ 16'hA5A5 : ~noise_reg;
endmodule : dsa_far_model
`default_nettype wire

// File: bench/dsa_access_unit_tb_top.sv
// Self-checking bench for the data-space access unit.
`timescale 1ns/10ps
`default_nettype none
module dsa_access_unit_tb_top;
  import dsa_pkg::*;
  logic          core_clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  dsa_agu_req_t  x_req_in = '0;
  dsa_agu_req_t  y_req_in = '0;
  dsa_agu_req_t  w_req_in = '0;
  dsa_circ_cfg_t x_cfg_in = '0;
  dsa_circ_cfg_t y_cfg_in = '0;
  dsa_circ_cfg_t w_cfg_in = '0;
  logic          near_direct_in = 1'b0;
  logic          dual_op_in = 1'b0;
  logic          window_enable_in = 1'b0;
  logic          trap_ack_in = 1'b0;
  logic [7:0]    program_window_page_in = 8'h00;
  logic [15:0]   wdata_in = 16'h0000;
  logic [15:0]   wreg_old_in = 16'h0000;
  logic [15:0]   prog_data_in, ctl_rdata_in, x_ptr_next_out, y_ptr_next_out;
  logic [15:0]   w_ptr_next_out, x_rdata_out, y_rdata_out, wreg_out;
  logic [15:0]   ctl_raddr_out, ctl_waddr_out, ctl_wdata_out, fault_addr_out;
  logic [21:0]   prog_addr_out;
  logic [1:0]    ctl_wstrb_out;
  logic          ctl_rhit_in, x_rvalid_out, x_dma_region_out, y_rvalid_out;
  logic          wr_done_out, wr_dropped_out, prog_rd_out, ctl_rd_out;
  logic          ctl_wr_out, addr_err_trap_out, fault_pending_out;
  logic [15:0]   px, py, pw;
  int            fail_count = 0;
  int            comparisons = 0;
  int            cycles = 0;

  always #20 core_clk_in = ~core_clk_in;

  dsa_access_unit dsa_access_unit_inst (.*);
  dsa_far_model dsa_far_model_inst (
    .core_clk_in (core_clk_in),   .rd_in     (ctl_rd_out),
    .raddr_in    (ctl_raddr_out), .wr_in     (ctl_wr_out),
    .waddr_in    (ctl_waddr_out), .wstrb_in  (ctl_wstrb_out),
    .wdata_in    (ctl_wdata_out), .prd_in    (prog_rd_out),
    .paddr_in    (prog_addr_out), .rdata_out (ctl_rdata_in),
    .rhit_out    (ctl_rhit_in),   .pdata_out (prog_data_in)
  );

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // The whole run needs well under a hundred cycles.
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  function automatic dsa_agu_req_t rq(logic b, logic [15:0] p,
                                      dsa_amode_t m = DSA_AM_DIRECT);
    return '{1'b1, b, m, p};
  endfunction : rq

  // One request cycle; pointer updates are sampled while it stands.
  task automatic cyc(dsa_agu_req_t x, dsa_agu_req_t w, logic [15:0] d);
    @(negedge core_clk_in);
    x_req_in = x;
    w_req_in = w;
    wdata_in = d;
    #1;
    px = x_ptr_next_out;
    py = y_ptr_next_out;
    pw = w_ptr_next_out;
    @(negedge core_clk_in);
    x_req_in = '0;
    y_req_in = '0;
    w_req_in = '0;
  endtask : cyc

  task automatic rd(logic b, logic [15:0] p);
    cyc(rq(b, p), '0, 16'h0000);
  endtask : rd

  task automatic wr(logic b, logic [15:0] p, logic [15:0] d);
    cyc('0, rq(b, p), d);
  endtask : wr

  task automatic ack;
    @(negedge core_clk_in);
    trap_ack_in = 1'b1;
    @(negedge core_clk_in);
    trap_ack_in = 1'b0;
  endtask : ack

  task automatic t_lanes;
    wr(0, 16'h1000, 16'hBEEF);
    chk("wr_done", wr_done_out, 16'h0001);
    wr(1, 16'h1001, 16'h0012);
    rd(0, 16'h1000);
    chk("word", x_rdata_out, 16'h12EF);
    wreg_old_in = 16'hAA55;
    rd(1, 16'h1001);
    chk("byte_hi", x_rdata_out, 16'h0012);
    chk("wreg", wreg_out, 16'hAA12);
    rd(1, 16'h1000);
    chk("byte_lo", x_rdata_out, 16'h00EF);
    near_direct_in = 1'b1;
    rd(0, 16'hF000);
    chk("near", x_rdata_out, 16'h12EF);
    near_direct_in = 1'b0;
    $display("lane test done");
  endtask : t_lanes

  task automatic t_map;
    rd(0, 16'h7800);
    chk("beyond", x_rdata_out, 16'h0000);
    wr(0, 16'h7002, 16'h3C3C);
    rd(0, 16'h7002);
    chk("dma_data", x_rdata_out, 16'h3C3C);
    chk("dma_flag", x_dma_region_out, 16'h0001);
    rd(0, 16'h8006);
    chk("win_off", x_rdata_out, 16'h0000);
    window_enable_in = 1'b1;
    program_window_page_in = 8'h03;
    rd(0, 16'h8006);
    chk("window", x_rdata_out, 16'hC003 ^ 16'hA5A5);
    window_enable_in = 1'b0;
    wr(0, 16'h0020, 16'h1234);
    wr(1, 16'h0021, 16'h0056);
    rd(0, 16'h0020);
    chk("ctl", x_rdata_out, 16'h5634);
    rd(0, 16'h0100);
    chk("ctl_empty", x_rdata_out, 16'h0000);
    $display("map test done");
  endtask : t_map

  task automatic t_trap;
    rd(0, 16'h1003);
    chk("trap", addr_err_trap_out, 16'h0001);
    chk("fault_addr", fault_addr_out, 16'h1003);
    chk("rvalid", x_rvalid_out, 16'h0001);
    wr(0, 16'h0021, 16'hFFFF);
    chk("dropped", wr_dropped_out, 16'h0001);
    chk("no_retrap", addr_err_trap_out, 16'h0000);
    chk("held", fault_addr_out, 16'h1003);
    ack();
    chk("cleared", fault_pending_out, 16'h0000);
    wr(0, 16'h0021, 16'hFFFF);
    chk("trap_wr", fault_addr_out, 16'h0021);
    ack();
    rd(0, 16'h0020);
    chk("kept", x_rdata_out, 16'h5634);
    $display("trap test done");
  endtask : t_trap

  task automatic t_agu;
    cyc(rq(1, 16'h1001, DSA_AM_POSTINC), rq(0, 16'h4800, DSA_AM_POSTINC),
        16'h5A5A);
    chk("x_step", px, 16'h1002);
    chk("w_step", pw, 16'h4802);
    x_cfg_in = '{16'h1000, 16'h1006, 16'h0010};
    y_cfg_in = '{16'h4800, 16'h4800, 16'h0000};
    dual_op_in = 1'b1;
    y_req_in = rq(0, 16'h4800, DSA_AM_MODULO);
    cyc(rq(0, 16'h1006, DSA_AM_MODULO), rq(0, 16'h4802), 16'h0F0F);
    chk("x_wrap", px, 16'h1000);
    chk("y_wrap", py, 16'h4800);
    chk("y_data", y_rdata_out, 16'h5A5A);
    chk("y_valid", y_rvalid_out, 16'h0001);
    chk("w_done", wr_done_out, 16'h0001);
    y_req_in = rq(0, 16'h4800, DSA_AM_BITREV);
    cyc(rq(0, 16'h1010, DSA_AM_BITREV), '0, 16'h0000);
    chk("x_brev", px, 16'h1008);
    chk("y_brev", py, 16'h4802);
    dual_op_in = 1'b0;
    $display("generator test done");
  endtask : t_agu

  initial
  begin
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_n_in = 1'b1;
    @(negedge core_clk_in);
    chk("pending", fault_pending_out, 16'h0000);
    t_lanes();
    t_map();
    t_trap();
    t_agu();
    finish_test();
  end
endmodule : dsa_access_unit_tb_top
`default_nettype wire
